// >>> core/sos_selector.sv
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "sos_params.svh"
// Contract
// - two relays and one open-collector output, each with its own selector code.
// - codes 100 to 152 drive the inverse of function code minus 100.
// - function 6 closes during baseblock, open otherwise.
// - function 8 closes when frequency reference comes from keypad.
// - function 9 closes when frequency reference loss is detected.
// - function 10 closes when run command comes from keypad.
// - function 11 closes whenever a fault is active.
// - function 12 follows the value the controller writes; holds otherwise.
// - function 13 closes on a PID feedback or overcurrent alarm, or with function 40 or 41; not on functions 26 and 27.
// - function 14 closes while a fault reset is attempted.
// - function 16 closes above level plus width, opens at level.
// - function 17 closes above level, opens at level minus width.
// - detections use magnitude, motor speed in closed-loop control.
// - functions 18 and 20 close when torque exceeds level longer than time.
// - function 22 closes while the motor turns in reverse.
// - function 24 closes while the motor regenerates.
// - function 25 closes during restarts, opens on clear or exhausted attempts.
// - function 26 closes when overload exceeds 90 percent of detection level.
// - function 27 closes when heatsink exceeds overheat level.
// - function 35 closes while the drive outputs frequency.
// - function 36 mirrors the drive-enable input.
// - function 38 closes in local mode, open in remote mode.
// - function 40 closes when feedback stays below low level past time.
// - function 41 closes when feedback stays above high level past time.
module sos_selector #(
  parameter int unsigned TICK_CYCLES = `SOS_TICK_CYCLES,
  parameter int unsigned DW          = 16
) (
  input  wire logic                sys_clk_i,
  input  wire logic                reset_i,
  input  wire logic [6:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  input  wire sos_pkg::sos_status_s status_i,
  input  wire sos_pkg::sos_meas_s   meas_i,
  output logic                     relay1_o,
  output logic                     relay2_o,
  output logic                     opencol_o
);
  localparam int unsigned NCFG = 17;
  localparam int unsigned TW   = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  function automatic logic [15:0] rst_val(input logic [4:0] idx);
    if (idx == `SOS_IDX_RELAY1) begin
      rst_val = `SOS_RST_RELAY1;
    end else if (idx == `SOS_IDX_RELAY2) begin
      rst_val = `SOS_RST_RELAY2;
    end else if (idx == `SOS_IDX_OPENCOL) begin
      rst_val = `SOS_RST_OPENCOL;
    end else begin
      rst_val = `SOS_RST_CFG;
    end
  endfunction : rst_val

  // maps a selector code onto the condition vector, with inversion
  function automatic logic sel_out(input logic [15:0] code, input logic [52:0] c);
    logic [15:0] base;
    base = code - `SOS_SEL_INV_BASE;
    if (code <= `SOS_SEL_MAX) begin
      sel_out = c[code[5:0]];
    end else if (code >= `SOS_SEL_INV_BASE && code <= `SOS_SEL_INV_MAX) begin
      sel_out = ~c[base[5:0]];
    end else begin
      sel_out = 1'b0;
    end
  endfunction : sel_out

  function automatic logic [DW:0] mag(input logic signed [DW-1:0] v);
    mag = v[DW-1] ? (DW+1)'(-{v[DW-1], v}) : {1'b0, v};
  endfunction : mag

  // ---------------- register bus ----------------
  logic [15:0] cfg [NCFG];
  logic [2:0]  out_q;
  wire  [4:0]  idx      = avs_address_i[6:2];
  wire         req      = avs_read_i || avs_write_i;
  wire         take     = req && !avs_waitrequest_o;
  wire         hit_cfg  = idx < `SOS_CFG_COUNT;
  wire         hit_stat = idx == `SOS_IDX_STATUS;
  wire  [15:0] wmask    = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  logic [31:0] rdata;
  logic [15:0] status_word;

  always_comb begin
    if (hit_cfg) begin
      rdata = {16'h0000, cfg[idx]};
    end else if (hit_stat) begin
      rdata = {16'h0000, status_word};
    end else begin
      rdata = 32'h0000_0000;
    end
  end

  // one wait state: request seen, then answered on the next edge
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(req && avs_waitrequest_o);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rdata;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NCFG; i++) begin
        cfg[i] <= rst_val(5'(i));
      end
    end else if (take && avs_write_i && hit_cfg) begin
      cfg[idx] <= (cfg[idx] & ~wmask) | (avs_writedata_i[15:0] & wmask);
    end
  end

  // ---------------- time base ----------------
  logic [TW-1:0] div_cnt;
  logic          tick;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || div_cnt == TW'(TICK_CYCLES - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tick <= 1'b0;
    end else begin
      tick <= div_cnt == TW'(TICK_CYCLES - 1);
    end
  end

  // ---------------- frequency detections ----------------
  wire [DW-1:0] flevel = cfg[`SOS_IDX_FLEVEL];
  wire [DW-1:0] fwidth = cfg[`SOS_IDX_FWIDTH];
  wire [DW:0]   speed_mag = status_i.closed_loop ? mag(meas_i.motor_speed)
                                                 : mag(meas_i.output_frequency);
  wire [DW:0]   lvl_plus  = {1'b0, flevel} + {1'b0, fwidth};
  wire [DW:0]   lvl_minus = (fwidth > flevel) ? '0 : {1'b0, flevel - fwidth};
  logic         fdet1;
  logic         fdet2;

  sos_hyst_cmp #(.DW(DW)) u_fdet1 (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .mag_i     (speed_mag),
    .on_thr_i  (lvl_plus),
    .off_thr_i ({1'b0, flevel}),
    .det_o     (fdet1)
  );

  sos_hyst_cmp #(.DW(DW)) u_fdet2 (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .mag_i     (speed_mag),
    .on_thr_i  ({1'b0, flevel}),
    .off_thr_i (lvl_minus),
    .det_o     (fdet2)
  );

  // ---------------- persistence timers ----------------
  // 0: torque 1, 1: torque 2, 2: pid low, 3: pid high
  wire  [3:0]    pers_cond = {
    meas_i.pid_feedback > cfg[`SOS_IDX_PHIGH_LVL],
    meas_i.pid_feedback < cfg[`SOS_IDX_PLOW_LVL],
    meas_i.torque > cfg[`SOS_IDX_TLEVEL2],
    meas_i.torque > cfg[`SOS_IDX_TLEVEL1]
  };
  wire  [DW-1:0] pers_time [4];
  logic [3:0]    pers_det;

  assign pers_time[0] = cfg[`SOS_IDX_TTIME1];
  assign pers_time[1] = cfg[`SOS_IDX_TTIME2];
  assign pers_time[2] = cfg[`SOS_IDX_PLOW_TIME];
  assign pers_time[3] = cfg[`SOS_IDX_PHIGH_TIME];

  for (genvar g = 0; g < 4; g++) begin : g_pers
    sos_persist_timer #(.DW(DW)) u_tmr (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .tick_i    (tick),
      .cond_i    (pers_cond[g]),
      .time_i    (pers_time[g]),
      .det_o     (pers_det[g])
    );
  end

  // ---------------- restart tracking ----------------
  sos_pkg::sos_restart_e rs_state;
  sos_pkg::sos_restart_e next_rs_state;
  logic [15:0]           rs_count;
  logic                  try_q;
  wire                   try_rise = status_i.restart_try && !try_q;
  wire                   try_fall = !status_i.restart_try && try_q;
  wire                   rs_limit = rs_count >= cfg[`SOS_IDX_RESTARTS];

  always_comb begin
    next_rs_state = rs_state;
    case (rs_state)
      sos_pkg::SOS_RS_IDLE: begin
        if (try_rise && cfg[`SOS_IDX_RESTARTS] != 16'h0000) begin
          next_rs_state = sos_pkg::SOS_RS_TRYING;
        end
      end
      sos_pkg::SOS_RS_TRYING: begin
        if (!status_i.fault) begin
          next_rs_state = sos_pkg::SOS_RS_IDLE;
        end else if (try_fall && rs_limit) begin
          next_rs_state = sos_pkg::SOS_RS_EXHAUSTED;
        end
      end
      sos_pkg::SOS_RS_EXHAUSTED: begin
        if (!status_i.fault) begin
          next_rs_state = sos_pkg::SOS_RS_IDLE;
        end
      end
      default: next_rs_state = sos_pkg::SOS_RS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rs_state <= sos_pkg::SOS_RS_IDLE;
      try_q    <= 1'b0;
    end else begin
      rs_state <= next_rs_state;
      try_q    <= status_i.restart_try;
    end
  end

  // attempts counted from the first try until the fault clears
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || next_rs_state == sos_pkg::SOS_RS_IDLE) begin
      rs_count <= 16'h0000;
    end else if (try_rise && !(&rs_count)) begin
      rs_count <= rs_count + 16'h0001;
    end
  end

  // ---------------- pre-alarms ----------------
  wire [19:0] ovl_lhs = 20'(meas_i.overload_level) * `SOS_PRE_DEN;
  wire [19:0] ovl_rhs = 20'(cfg[`SOS_IDX_OVL_LVL]) * `SOS_PRE_NUM;
  wire        ovl_pre = ovl_lhs > ovl_rhs;
  wire        oh_pre  = meas_i.heatsink_temp > cfg[`SOS_IDX_OH_LVL];

  // ---------------- condition vector ----------------
  logic [52:0] cond;
  logic [2:0]  comm_bits;

  assign comm_bits = cfg[`SOS_IDX_COMM][2:0];

  always_comb begin
    cond                       = '0;
    cond[`SOS_F_BASEBLOCK]     = status_i.baseblock;
    cond[`SOS_F_FREF_SRC]      = status_i.freq_ref_keypad;
    cond[`SOS_F_FREF_LOSS]     = status_i.freq_ref_loss;
    cond[`SOS_F_RUN_SRC]       = status_i.run_cmd_keypad;
    cond[`SOS_F_FAULT]         = status_i.fault;
    cond[`SOS_F_ALARM]         = status_i.pid_feedback_high_alarm
                               || status_i.pid_feedback_low_alarm
                               || status_i.overcurrent_alarm
                               || pers_det[2] || pers_det[3];
    cond[`SOS_F_FLT_RESTART]   = status_i.fault_reset_req;
    cond[`SOS_F_FDET1]         = fdet1;
    cond[`SOS_F_FDET2]         = fdet2;
    cond[`SOS_F_TRQ1]          = pers_det[0];
    cond[`SOS_F_TRQ2]          = pers_det[1];
    cond[`SOS_F_REVERSE]       = status_i.reverse;
    cond[`SOS_F_REGEN]         = status_i.regenerating;
    cond[`SOS_F_RESTART]       = rs_state == sos_pkg::SOS_RS_TRYING;
    cond[`SOS_F_OVL_PRE]       = ovl_pre;
    cond[`SOS_F_OVERHEAT]      = oh_pre;
    cond[`SOS_F_FREQ_OUT]      = status_i.freq_output_active;
    cond[`SOS_F_ENABLE]        = status_i.enable_input;
    cond[`SOS_F_LOCAL]         = status_i.local_mode;
    cond[`SOS_F_PID_LOW]       = pers_det[2];
    cond[`SOS_F_PID_HIGH]      = pers_det[3];
  end

  // ---------------- output selection ----------------
  for (genvar o = 0; o < 3; o++) begin : g_out
    logic [52:0] cond_o;
    always_comb begin
      cond_o              = cond;
      cond_o[`SOS_F_COMM] = comm_bits[o];
    end
    always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
        out_q[o] <= 1'b0;
      end else begin
        out_q[o] <= sel_out(cfg[o], cond_o);
      end
    end
  end

  assign relay1_o    = out_q[0];
  assign relay2_o    = out_q[1];
  assign opencol_o   = out_q[2];
  assign status_word = {2'b00, rs_state, pers_det, fdet2, fdet1, oh_pre, ovl_pre,
                        1'b0, out_q};

  // ---------------- checks ----------------
  property p_baseblock;
    @(posedge sys_clk_i) disable iff (reset_i)
      (cfg[0] == 16'h0006 && status_i.baseblock) |=> relay1_o;
  endproperty
  a_baseblock: assert property (p_baseblock) else $error("baseblock not shown");

  property p_fault_inv;
    @(posedge sys_clk_i) disable iff (reset_i)
      (cfg[1] == 16'h006F && status_i.fault) |=> !relay2_o;
  endproperty
  a_fault_inv: assert property (p_fault_inv) else $error("inverted fault wrong");

  property p_fault;
    @(posedge sys_clk_i) disable iff (reset_i)
      (cfg[1] == 16'h000B) |=> (relay2_o == $past(status_i.fault));
  endproperty
  a_fault: assert property (p_fault) else $error("fault not mirrored");

  property p_reserved;
    @(posedge sys_clk_i) disable iff (reset_i)
      (cfg[2] == 16'h0007) ##1 (cfg[2] == 16'h006B) |=> !$past(opencol_o) && opencol_o;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code drove output");

  property p_comm;
    @(posedge sys_clk_i) disable iff (reset_i)
      (cfg[0] == 16'h000C) |=> (relay1_o == $past(comm_bits[0]));
  endproperty
  a_comm: assert property (p_comm) else $error("comm output not followed");

  property p_restart_clear;
    @(posedge sys_clk_i) disable iff (reset_i)
      (rs_state == sos_pkg::SOS_RS_TRYING && !status_i.fault)
        |=> rs_state == sos_pkg::SOS_RS_IDLE ##1 !cond[`SOS_F_RESTART];
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart not ended");

  property p_magnitude;
    @(posedge sys_clk_i) disable iff (reset_i)
      (status_i.closed_loop && !meas_i.motor_speed[DW-1]) |->
        speed_mag == {1'b0, meas_i.motor_speed};
  endproperty
  a_magnitude: assert property (p_magnitude) else $error("speed source wrong");

endmodule : sos_selector

// >>> core/sos_params.svh
`ifndef SOS_PARAMS_SVH
`define SOS_PARAMS_SVH

// clock and time base (all times counted in 1 ms ticks)
`define SOS_CLK_PERIOD_NS   4
`define SOS_TICK_NS         1000000
`define SOS_TICK_CYCLES     ((`SOS_TICK_NS + `SOS_CLK_PERIOD_NS - 1) / `SOS_CLK_PERIOD_NS)

// selector code ranges
`define SOS_SEL_MAX         16'h0034
`define SOS_SEL_INV_BASE    16'h0064
`define SOS_SEL_INV_MAX     16'h0098

// function codes carried by the condition vector
`define SOS_F_BASEBLOCK     6'h06
`define SOS_F_RESERVED7     6'h07
`define SOS_F_FREF_SRC      6'h08
`define SOS_F_FREF_LOSS     6'h09
`define SOS_F_RUN_SRC       6'h0A
`define SOS_F_FAULT         6'h0B
`define SOS_F_COMM          6'h0C
`define SOS_F_ALARM         6'h0D
`define SOS_F_FLT_RESTART   6'h0E
`define SOS_F_FDET1         6'h10
`define SOS_F_FDET2         6'h11
`define SOS_F_TRQ1          6'h12
`define SOS_F_TRQ2          6'h14
`define SOS_F_REVERSE       6'h16
`define SOS_F_REGEN         6'h18
`define SOS_F_RESTART       6'h19
`define SOS_F_OVL_PRE       6'h1A
`define SOS_F_OVERHEAT      6'h1B
`define SOS_F_FREQ_OUT      6'h23
`define SOS_F_ENABLE        6'h24
`define SOS_F_LOCAL         6'h26
`define SOS_F_PID_LOW       6'h28
`define SOS_F_PID_HIGH      6'h29

// overload pre-alarm ratio 9/10
`define SOS_PRE_NUM         20'h0_0009
`define SOS_PRE_DEN         20'h0_000A

// register indices, byte address = index * 4
`define SOS_IDX_RELAY1      5'h00
`define SOS_IDX_RELAY2      5'h01
`define SOS_IDX_OPENCOL     5'h02
`define SOS_IDX_FLEVEL      5'h03
`define SOS_IDX_FWIDTH      5'h04
`define SOS_IDX_TLEVEL1     5'h05
`define SOS_IDX_TTIME1      5'h06
`define SOS_IDX_TLEVEL2     5'h07
`define SOS_IDX_TTIME2      5'h08
`define SOS_IDX_RESTARTS    5'h09
`define SOS_IDX_PLOW_LVL    5'h0A
`define SOS_IDX_PLOW_TIME   5'h0B
`define SOS_IDX_PHIGH_LVL   5'h0C
`define SOS_IDX_PHIGH_TIME  5'h0D
`define SOS_IDX_OVL_LVL     5'h0E
`define SOS_IDX_OH_LVL      5'h0F
`define SOS_IDX_COMM        5'h10
`define SOS_IDX_STATUS      5'h11
`define SOS_CFG_COUNT       5'h11

// reset values
`define SOS_RST_RELAY1      16'h0000
`define SOS_RST_RELAY2      16'h000B
`define SOS_RST_OPENCOL     16'h0001
`define SOS_RST_CFG         16'h0000

`endif

// >>> core/sos_pkg.sv
package sos_pkg;

  typedef struct packed {
    logic baseblock;
    logic freq_ref_keypad;
    logic freq_ref_loss;
    logic run_cmd_keypad;
    logic fault;
    logic fault_reset_req;
    logic pid_feedback_high_alarm;
    logic pid_feedback_low_alarm;
    logic overcurrent_alarm;
    logic reverse;
    logic regenerating;
    logic restart_try;
    logic freq_output_active;
    logic enable_input;
    logic local_mode;
    logic closed_loop;
  } sos_status_s;

  typedef struct packed {
    logic signed [15:0] output_frequency;
    logic signed [15:0] motor_speed;
    logic        [15:0] torque;
    logic        [15:0] pid_feedback;
    logic        [15:0] overload_level;
    logic        [15:0] heatsink_temp;
  } sos_meas_s;

  typedef enum logic [1:0] {
    SOS_RS_IDLE      = 2'b00,
    SOS_RS_TRYING    = 2'b01,
    SOS_RS_EXHAUSTED = 2'b10
  } sos_restart_e;

endpackage : sos_pkg

// >>> core/sos_persist_timer.sv
`timescale 1ns/1ps
module sos_persist_timer #(
  parameter int unsigned DW = 16
) (
  input  wire logic          sys_clk_i,
  input  wire logic          reset_i,
  input  wire logic          tick_i,
  input  wire logic          cond_i,
  input  wire logic [DW-1:0] time_i,
  output logic               det_o
);
  logic [DW:0] count;
  wire         over = count > {1'b0, time_i};
  wire         sat  = &count;

  // counts ticks while the condition holds, any gap restarts it
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !cond_i) begin
      count <= '0;
    end else if (tick_i && !sat) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      det_o <= 1'b0;
    end else begin
      det_o <= cond_i && over;
    end
  end

  property p_drop;
    @(posedge sys_clk_i) disable iff (reset_i) !cond_i |=> !det_o;
  endproperty
  a_drop: assert property (p_drop) else $error("persist detect not dropped");

endmodule : sos_persist_timer

// >>> core/sos_hyst_cmp.sv
`timescale 1ns/1ps
module sos_hyst_cmp #(
  parameter int unsigned DW = 16
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [DW:0] mag_i,
  input  wire logic [DW:0] on_thr_i,
  input  wire logic [DW:0] off_thr_i,
  output logic             det_o
);
  // closes above on threshold, opens at or below off threshold
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      det_o <= 1'b0;
    end else if (mag_i > on_thr_i) begin
      det_o <= 1'b1;
    end else if (mag_i <= off_thr_i) begin
      det_o <= 1'b0;
    end
  end

  property p_close;
    @(posedge sys_clk_i) disable iff (reset_i) (mag_i > on_thr_i) |=> det_o;
  endproperty
  a_close: assert property (p_close) else $error("detect did not close");

  property p_hold;
    @(posedge sys_clk_i) disable iff (reset_i)
      (det_o && mag_i > off_thr_i) |=> det_o;
  endproperty
  a_hold: assert property (p_hold) else $error("detect released early");

endmodule : sos_hyst_cmp

// >>> bench/sos_load_model.sv
`timescale 1ns/1ps
module sos_load_model (
  input  wire logic       sys_clk_i,
  input  wire logic       relay1_i,
  input  wire logic       relay2_i,
  input  wire logic       opencol_i,
  output logic      [2:0] sensed_o
);
  // wired equipment senses the contacts one clock behind the pins
  always_ff @(posedge sys_clk_i) begin
    sensed_o <= {opencol_i, relay2_i, relay1_i};
  end
endmodule : sos_load_model

// >>> bench/tb_status_output_selector.sv
`timescale 1ns/1ps
module tb_status_output_selector;
  logic               sys_clk;
  logic               reset;
  logic [6:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic [15:0]        st;
  sos_pkg::sos_meas_s meas;
  logic               relay1;
  logic               relay2;
  logic               opencol;
  logic [2:0]         sensed;
  logic [31:0]        q;
  int                 miscompares;
  int                 compares;
  wire  [31:0]        outs = {29'h0, opencol, relay2, relay1};

  sos_selector #(.TICK_CYCLES(4)) u_dut (
    .sys_clk_i(sys_clk), .reset_i(reset), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .status_i(sos_pkg::sos_status_s'(st)),
    .meas_i(meas), .relay1_o(relay1), .relay2_o(relay2), .opencol_o(opencol));

  sos_load_model u_load (
    .sys_clk_i(sys_clk), .relay1_i(relay1), .relay2_i(relay2),
    .opencol_i(opencol), .sensed_o(sensed));

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    @(posedge sys_clk iff avs_waitrequest === 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic t_reset();
    bus(1'b0, 7'h00, 32'h0);
    chk(q, 32'h0000_0000);
    bus(1'b0, 7'h04, 32'h0);
    chk(q, 32'h0000_000B);
    bus(1'b0, 7'h08, 32'h0);
    chk(q, 32'h0000_0001);
    bus(1'b1, 7'h48, 32'h0000_FFFF);
    bus(1'b0, 7'h48, 32'h0);
    chk(q, 32'h0000_0000);
    chk(outs, 32'h0000_0000);
    $display("reset test done");
  endtask : t_reset

  task automatic t_direct();
    int code [12] = '{6, 8, 9, 10, 11, 13, 14, 22, 24, 35, 36, 38};
    int bitn [12] = '{15, 14, 13, 12, 11, 9, 10, 6, 5, 3, 2, 1};
    for (int i = 0; i < 12; i++) begin
      bus(1'b1, 7'h00, 32'(code[i]));
      bus(1'b1, 7'h04, 32'(code[i] + 100));
      st <= 16'h0001 << bitn[i];
      cyc(4);
      chk(outs, 32'h0000_0001);
      st <= 16'h0000;
      cyc(4);
      chk(outs, 32'h0000_0002);
    end
    bus(1'b1, 7'h00, 32'h0000_0007);
    bus(1'b1, 7'h04, 32'h0000_0082);
    bus(1'b1, 7'h08, 32'h0000_0007);
    cyc(4);
    chk(outs, 32'h0000_0002);
    bus(1'b1, 7'h08, 32'h0000_006B);
    cyc(4);
    chk(outs, 32'h0000_0006);
    $display("direct test done");
  endtask : t_direct

  task automatic t_fdet();
    int f [9] = '{110, 121, 101, 100, 81, 80, -121, 0, -121};
    int e [9] = '{2, 3, 3, 2, 2, 0, 3, 0, 3};
    bus(1'b1, 7'h0C, 32'h0000_0064);
    bus(1'b1, 7'h10, 32'h0000_0014);
    bus(1'b1, 7'h00, 32'h0000_0010);
    bus(1'b1, 7'h04, 32'h0000_0011);
    bus(1'b1, 7'h08, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      if (i < 7) begin
        meas.output_frequency <= 16'(f[i]);
      end else begin
        st               <= 16'h0001;
        meas.motor_speed <= 16'(f[i]);
      end
      cyc(5);
      chk(outs, 32'(e[i]));
    end
    st   <= 16'h0000;
    meas <= '0;
    $display("frequency test done");
  endtask : t_fdet

  task automatic t_timer();
    meas.pid_feedback <= 16'h0064;
    bus(1'b1, 7'h14, 32'h0000_0032);
    bus(1'b1, 7'h18, 32'h0000_0003);
    bus(1'b1, 7'h1C, 32'h0000_0032);
    bus(1'b1, 7'h20, 32'h0000_0003);
    bus(1'b1, 7'h28, 32'h0000_000A);
    bus(1'b1, 7'h2C, 32'h0000_0003);
    bus(1'b1, 7'h00, 32'h0000_0012);
    bus(1'b1, 7'h04, 32'h0000_0014);
    bus(1'b1, 7'h08, 32'h0000_0028);
    meas.torque       <= 16'h003C;
    meas.pid_feedback <= 16'h0005;
    cyc(8);
    chk(outs, 32'h0000_0000);
    cyc(30);
    chk(outs, 32'h0000_0007);
    meas.torque       <= 16'h0000;
    meas.pid_feedback <= 16'h0014;
    cyc(4);
    chk(outs, 32'h0000_0000);
    bus(1'b1, 7'h30, 32'h0000_000F);
    bus(1'b1, 7'h34, 32'h0000_0003);
    bus(1'b1, 7'h08, 32'h0000_0029);
    cyc(30);
    chk(outs, 32'h0000_0004);
    meas <= '0;
    cyc(4);
    $display("timer test done");
  endtask : t_timer

  task automatic t_levels();
    meas.pid_feedback <= 16'h000C;
    bus(1'b1, 7'h38, 32'h0000_0064);
    bus(1'b1, 7'h3C, 32'h0000_0046);
    bus(1'b1, 7'h00, 32'h0000_001A);
    bus(1'b1, 7'h04, 32'h0000_001B);
    meas.overload_level <= 16'h005A;
    meas.heatsink_temp  <= 16'h0046;
    cyc(5);
    chk(outs, 32'h0000_0000);
    meas.overload_level <= 16'h005B;
    meas.heatsink_temp  <= 16'h0047;
    cyc(5);
    chk(outs, 32'h0000_0003);
    bus(1'b0, 7'h44, 32'h0);
    chk(q, 32'h0000_0033);
    meas <= '0;
    $display("level test done");
  endtask : t_levels

  task automatic t_restart();
    bus(1'b1, 7'h24, 32'h0000_0001);
    bus(1'b1, 7'h00, 32'h0000_0019);
    st <= 16'h0810;
    cyc(5);
    chk(outs, 32'h0000_0001);
    st <= 16'h0800;
    cyc(5);
    chk(outs, 32'h0000_0000);
    st <= 16'h0000;
    bus(1'b1, 7'h24, 32'h0000_0002);
    st <= 16'h0810;
    cyc(5);
    chk(outs, 32'h0000_0001);
    st <= 16'h0010;
    cyc(5);
    chk(outs, 32'h0000_0000);
    st <= 16'h0000;
    $display("restart test done");
  endtask : t_restart

  task automatic t_comm();
    bus(1'b1, 7'h00, 32'h0000_000C);
    bus(1'b1, 7'h04, 32'h0000_000C);
    bus(1'b1, 7'h08, 32'h0000_000C);
    cyc(4);
    chk(outs, 32'h0000_0000);
    bus(1'b1, 7'h40, 32'h0000_0005);
    cyc(3);
    chk(outs, 32'h0000_0005);
    st <= 16'hFFFF;
    cyc(4);
    chk(outs, 32'h0000_0005);
    chk({29'h0, sensed}, 32'h0000_0005);
    st <= 16'h0000;
    $display("comm test done");
  endtask : t_comm

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    reset         = 1'b1;
    avs_address   = 7'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    st            = 16'h0000;
    meas          = '0;
    miscompares   = 0;
    compares      = 0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    cyc(2);
    t_reset();
    t_direct();
    t_fdet();
    t_timer();
    t_levels();
    t_restart();
    t_comm();
    finish_test();
  end

  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule : tb_status_output_selector
